// file: common/dsa_pkg.sv
package dsa_pkg;

  // time base
  localparam int DSA_CLK_KHZ = 125000;
  localparam int DSA_HALF_SEC_MS = 500;
  localparam int DSA_HALF_SEC_CYC = DSA_CLK_KHZ * DSA_HALF_SEC_MS;
  localparam logic [11:0] DSA_MAX_SECONDS = 12'hE10;

  // register byte offsets
  localparam logic [7:0] DSA_CFG_OFS = 8'h00;
  localparam logic [7:0] DSA_RANGE_OFS = 8'h04;
  localparam logic [7:0] DSA_TRIP1_OFS = 8'h08;
  localparam logic [7:0] DSA_TRIP2_OFS = 8'h0C;
  localparam logic [7:0] DSA_HYST_OFS = 8'h10;
  localparam logic [7:0] DSA_DELAY_OFS = 8'h14;
  localparam logic [7:0] DSA_SILENCE_OFS = 8'h18;
  localparam logic [7:0] DSA_STATUS_OFS = 8'h1C;
  localparam logic [7:0] DSA_IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] DSA_IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] DSA_EDIT_OFS = 8'h28;
  localparam logic [7:0] DSA_EDIT_VAL_OFS = 8'h2C;
  localparam logic [7:0] DSA_UNMAPPED = 8'hFF;

  // field positions
  localparam int DSA_CFG_EN = 0;
  localparam int DSA_CFG_HIGH = 1;
  localparam int DSA_CFG_SENSE = 2;
  localparam int DSA_CFG_STRIDE = 4;
  localparam int DSA_CFG_ALT = 8;
  localparam int DSA_HALF_W = 16;
  localparam int DSA_STS_STRIDE = 4;
  localparam int DSA_STS_SEL = 8;
  localparam int DSA_IRQ_REJECT = 2;
  localparam int DSA_EDIT_DIGIT_POS = 4;

  // reset values and edit start digit
  localparam logic signed [15:0] DSA_RANGE_LO_RST = 16'hFF83;
  localparam logic signed [15:0] DSA_RANGE_HI_RST = 16'h278D;
  localparam logic [2:0] DSA_EDIT_TOP_DIGIT = 3'h4;

  // per channel configuration
  typedef struct packed {
    logic en;
    logic high;
    logic sense;
    logic signed [15:0] sp;
    logic [15:0] hyst;
    logic [11:0] delay;
    logic [11:0] silence;
  } dsa_chan_cfg_t;

  // per channel state
  typedef struct packed {
    logic cond;
    logic active;
    logic delaying;
    logic silent;
  } dsa_chan_sts_t;

endpackage

// file: verilog/dsa_chan.sv
`timescale 1ns/10ps
module dsa_chan import dsa_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // time base and operator
  input wire logic sec_tick,
  input wire logic accept,
  // configuration and measurement
  input wire dsa_chan_cfg_t cfg,
  input wire logic signed [15:0] disp_value,
  // channel state
  output dsa_chan_sts_t sts
);

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ACTIVE, ST_SILENT} dsa_chan_state_t;

  dsa_chan_state_t state_r, state_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic cond_r;
  wire logic cond_nxt;
  wire logic signed [17:0] disp_x;
  wire logic signed [17:0] sp_x;
  wire logic signed [17:0] clr_hi;
  wire logic signed [17:0] clr_lo;
  wire logic cnt_done_dly;
  wire logic cnt_done_sil;

  // deadband levels in display units, widened so no overflow
  assign disp_x = 18'(disp_value);
  assign sp_x = 18'(cfg.sp);
  assign clr_hi = sp_x - signed'({2'h0, cfg.hyst});
  assign clr_lo = sp_x + signed'({2'h0, cfg.hyst});

  // disable forces idle but leaves stored parameters alone
  assign cond_nxt = !cfg.en ? 1'b0 :
    cfg.high ? (cond_r ? !(disp_x < clr_hi) : (disp_x >= sp_x)) :
    (cond_r ? !(disp_x > clr_lo) : (disp_x <= sp_x));
  assign cnt_done_dly = ({1'b0, cnt_r} + 13'h0001) >= {1'b0, cfg.delay};
  assign cnt_done_sil = ({1'b0, cnt_r} + 13'h0001) >= {1'b0, cfg.silence};

  // alarm sequencing; first second of a count may be partial
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 12'h000;
        if (cond_r) begin
          state_nxt = (cfg.delay == 12'h000) ? ST_ACTIVE : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!cond_r) begin
          state_nxt = ST_IDLE;
        end else if (sec_tick) begin
          if (cnt_done_dly) begin
            state_nxt = ST_ACTIVE;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
      end
      ST_ACTIVE: begin
        cnt_nxt = 12'h000;
        if (!cond_r) begin
          state_nxt = ST_IDLE;
        end else if (accept && cfg.silence != 12'h000) begin
          state_nxt = ST_SILENT;
        end
      end
      ST_SILENT: begin
        if (!cond_r) begin
          state_nxt = ST_IDLE;
        end else if (sec_tick) begin
          if (cnt_done_sil) begin
            state_nxt = ST_ACTIVE;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = 12'h000;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
      cond_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cond_r <= cond_nxt;
    end
  end

  // state flags toward the top level
  assign sts = '{cond: cond_r, active: (state_r == ST_ACTIVE),
                 delaying: (state_r == ST_DELAY), silent: (state_r == ST_SILENT)};

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_disabled_no_cond: assert property (!cfg.en |=> !cond_r)
    else $error("disabled channel holds a condition");
  a_high_sets: assert property (cfg.en && cfg.high && disp_x >= sp_x |=> cond_r)
    else $error("high alarm missed setpoint");
  a_low_clears: assert property (cfg.en && !cfg.high && cond_r && disp_x > clr_lo |=> !cond_r)
    else $error("low alarm failed to clear");
  a_zero_delay: assert property (state_r == ST_IDLE && cond_r && cfg.delay == 12'h000
    |=> state_r == ST_ACTIVE)
    else $error("zero delay did not activate at once");
  a_break_restart: assert property (state_r == ST_DELAY && !cond_r |=> state_r == ST_IDLE)
    else $error("broken condition kept delay running");
  a_delay_full: assert property (state_r == ST_DELAY ##1 state_r == ST_ACTIVE
    |-> ($past(cnt_r) + 12'h001) >= $past(cfg.delay))
    else $error("output active before delay expired");
  a_accept_silence: assert property (state_r == ST_ACTIVE && cond_r && accept
    && cfg.silence != 12'h000 |=> state_r == ST_SILENT)
    else $error("accept did not silence output");
  a_no_accept_zero: assert property (state_r == ST_ACTIVE && cfg.silence == 12'h000
    |=> state_r != ST_SILENT)
    else $error("accept acted with zero silence time");

  c_delay_to_active: cover property (state_r == ST_DELAY ##1 state_r == ST_ACTIVE);
  c_silence_back: cover property (state_r == ST_SILENT ##1 state_r == ST_ACTIVE);

endmodule

// file: verilog/dsa_top.sv
`timescale 1ns/10ps
module dsa_top import dsa_pkg::*; #(
  parameter int HALF_SEC_CYC = DSA_HALF_SEC_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement and front panel
  input wire logic signed [15:0] disp_value,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic btn_prog,
  input wire logic btn_accept,
  // alarm outputs and indication
  output logic [1:0] alarm_sw,
  output logic [1:0] annunciator,
  output logic [1:0] display_sel,
  output logic irq
);

  typedef enum logic {ED_IDLE, ED_DIGIT} dsa_edit_state_t;

  // decimal weight of the digit under edit
  function automatic logic signed [17:0] digit_weight(input logic [2:0] d);
    case (d)
      3'h0: digit_weight = 18'sh00001;
      3'h1: digit_weight = 18'sh0000A;
      3'h2: digit_weight = 18'sh00064;
      3'h3: digit_weight = 18'sh003E8;
      default: digit_weight = 18'sh02710;
    endcase
  endfunction

  // setpoint acceptance window from the present calibration
  function automatic logic in_range(input logic signed [17:0] v,
                                    input logic signed [15:0] lo,
                                    input logic signed [15:0] hi);
    in_range = (v >= 18'(lo)) && (v <= 18'(hi));
  endfunction

  // over-range seconds saturate rather than wrap
  function automatic logic [11:0] clamp_sec(input logic [15:0] v);
    clamp_sec = (v > {4'h0, DSA_MAX_SECONDS}) ? DSA_MAX_SECONDS : v[11:0];
  endfunction

  // bus state
  logic [7:0] addr_r;
  logic wr_pend_r, rd_pend_r;
  logic [31:0] rd_mux;
  // stored configuration
  logic [1:0] en_r, high_r, sense_r;
  logic alt_r;
  logic signed [15:0] lo_lim_r, hi_lim_r;
  logic signed [15:0] trip_r [2];
  logic [15:0] hyst_r [2];
  logic [11:0] delay_r [2];
  logic [11:0] sil_r [2];
  // interrupts
  logic [2:0] irq_stat_r, irq_mask_r;
  wire logic [2:0] irq_evt;
  wire logic [2:0] irq_stat_nxt;
  // time base
  logic [25:0] half_cnt_r;
  logic half_tick_r, sec_tick_r, blink_r, sec_phase_r;
  // buttons
  logic [3:0] btn_q_r;
  wire logic [3:0] btn_now;
  wire logic [3:0] btn_press;
  // channels
  dsa_chan_cfg_t chan_cfg [2];
  dsa_chan_sts_t chan_sts [2];
  wire logic [1:0] act;
  logic [1:0] act_q_r;
  // display alternation
  logic last_ch_r;
  wire logic sel_ok, pick_ch;
  // editor
  dsa_edit_state_t ed_state_r;
  logic ed_tgt_r;
  logic [2:0] ed_digit_r;
  logic signed [17:0] ed_val_r;
  wire logic ed_start, ed_commit, ed_ok;
  // write strobes
  wire logic addr_take;
  wire logic wr_cfg, wr_range, wr_hyst, wr_delay, wr_sil;
  wire logic wr_stat, wr_mask, wr_edit;
  wire logic [1:0] wr_trip;
  wire logic [1:0] trip_ok;

  // address phase capture; anything above the map decodes unmapped
  assign addr_take = hsel && hready && htrans[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= DSA_UNMAPPED;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      if (addr_take) begin
        addr_r <= (haddr[31:6] == 26'h0) ? {2'h0, haddr[5:2], 2'h0} : DSA_UNMAPPED;
      end
      wr_pend_r <= addr_take && hwrite;
      rd_pend_r <= addr_take && !hwrite;
      // reads take one wait state so they always see committed writes
      hreadyout <= !(addr_take && !hwrite);
      if (rd_pend_r) begin
        hrdata <= rd_mux;
      end
    end
  end

  // write decode in the data phase
  assign wr_cfg = wr_pend_r && addr_r == DSA_CFG_OFS;
  assign wr_range = wr_pend_r && addr_r == DSA_RANGE_OFS;
  assign wr_trip[0] = wr_pend_r && addr_r == DSA_TRIP1_OFS;
  assign wr_trip[1] = wr_pend_r && addr_r == DSA_TRIP2_OFS;
  assign wr_hyst = wr_pend_r && addr_r == DSA_HYST_OFS;
  assign wr_delay = wr_pend_r && addr_r == DSA_DELAY_OFS;
  assign wr_sil = wr_pend_r && addr_r == DSA_SILENCE_OFS;
  assign wr_stat = wr_pend_r && addr_r == DSA_IRQ_STAT_OFS;
  assign wr_mask = wr_pend_r && addr_r == DSA_IRQ_MASK_OFS;
  assign wr_edit = wr_pend_r && addr_r == DSA_EDIT_OFS;
  assign trip_ok[0] = in_range(18'(signed'(hwdata[15:0])), lo_lim_r, hi_lim_r);
  assign trip_ok[1] = trip_ok[0];

  // read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_r)
      DSA_CFG_OFS: begin
        rd_mux[DSA_CFG_ALT] = alt_r;
        for (int i = 0; i < 2; i++) begin
          rd_mux[DSA_CFG_EN + i * DSA_CFG_STRIDE] = en_r[i];
          rd_mux[DSA_CFG_HIGH + i * DSA_CFG_STRIDE] = high_r[i];
          rd_mux[DSA_CFG_SENSE + i * DSA_CFG_STRIDE] = sense_r[i];
        end
      end
      DSA_RANGE_OFS: rd_mux = {hi_lim_r, lo_lim_r};
      DSA_TRIP1_OFS: rd_mux = 32'(trip_r[0]);
      DSA_TRIP2_OFS: rd_mux = 32'(trip_r[1]);
      DSA_HYST_OFS: rd_mux = {hyst_r[1], hyst_r[0]};
      DSA_DELAY_OFS: rd_mux = {4'h0, delay_r[1], 4'h0, delay_r[0]};
      DSA_SILENCE_OFS: rd_mux = {4'h0, sil_r[1], 4'h0, sil_r[0]};
      DSA_STATUS_OFS: begin
        rd_mux[DSA_STS_SEL +: 2] = display_sel;
        for (int i = 0; i < 2; i++) begin
          rd_mux[i * DSA_STS_STRIDE +: 4] = chan_sts[i];
        end
      end
      DSA_IRQ_STAT_OFS: rd_mux = {29'h0, irq_stat_r};
      DSA_IRQ_MASK_OFS: rd_mux = {29'h0, irq_mask_r};
      DSA_EDIT_OFS: begin
        rd_mux[0] = (ed_state_r == ED_DIGIT);
        rd_mux[1] = ed_tgt_r;
        rd_mux[DSA_EDIT_DIGIT_POS +: 3] = ed_digit_r;
      end
      DSA_EDIT_VAL_OFS: rd_mux = 32'(ed_val_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // configuration; a rejected setpoint keeps its old value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= 2'h0;
      high_r <= 2'h3;
      sense_r <= 2'h0;
      alt_r <= 1'b0;
      lo_lim_r <= DSA_RANGE_LO_RST;
      hi_lim_r <= DSA_RANGE_HI_RST;
      for (int i = 0; i < 2; i++) begin
        trip_r[i] <= 16'h0000;
        hyst_r[i] <= 16'h0000;
        delay_r[i] <= 12'h000;
        sil_r[i] <= 12'h000;
      end
    end else begin
      if (wr_range) begin
        lo_lim_r <= hwdata[15:0];
        hi_lim_r <= hwdata[31:16];
      end
      if (wr_cfg) begin
        alt_r <= hwdata[DSA_CFG_ALT];
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_cfg) begin
          en_r[i] <= hwdata[DSA_CFG_EN + i * DSA_CFG_STRIDE];
          high_r[i] <= hwdata[DSA_CFG_HIGH + i * DSA_CFG_STRIDE];
          sense_r[i] <= hwdata[DSA_CFG_SENSE + i * DSA_CFG_STRIDE];
        end
        if (wr_trip[i] && trip_ok[i]) begin
          trip_r[i] <= hwdata[15:0];
        end else if (ed_commit && ed_ok && ed_tgt_r == i[0]) begin
          trip_r[i] <= ed_val_r[15:0];
        end
        if (wr_hyst) begin
          hyst_r[i] <= hwdata[i * DSA_HALF_W +: DSA_HALF_W];
        end
        if (wr_delay) begin
          delay_r[i] <= clamp_sec(hwdata[i * DSA_HALF_W +: DSA_HALF_W]);
        end
        if (wr_sil) begin
          sil_r[i] <= clamp_sec(hwdata[i * DSA_HALF_W +: DSA_HALF_W]);
        end
      end
    end
  end

  // half-second divider; seconds and blink derive from it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 26'h0;
      half_tick_r <= 1'b0;
      sec_tick_r <= 1'b0;
      sec_phase_r <= 1'b0;
      blink_r <= 1'b0;
    end else begin
      half_tick_r <= (half_cnt_r == 26'(HALF_SEC_CYC - 1));
      half_cnt_r <= (half_cnt_r == 26'(HALF_SEC_CYC - 1)) ? 26'h0 : half_cnt_r + 26'h1;
      sec_tick_r <= half_tick_r && sec_phase_r;
      if (half_tick_r) begin
        sec_phase_r <= !sec_phase_r;
        blink_r <= !blink_r;
      end
    end
  end

  // press detection: one pulse per rising button edge
  assign btn_now = {btn_accept, btn_prog, btn_down, btn_up};
  assign btn_press = btn_now & ~btn_q_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_q_r <= 4'h0;
    end else begin
      btn_q_r <= btn_now;
    end
  end

  // two identical channels
  for (genvar gi = 0; gi < 2; gi++) begin : g_chan
    assign chan_cfg[gi] = '{en: en_r[gi], high: high_r[gi], sense: sense_r[gi],
                            sp: trip_r[gi], hyst: hyst_r[gi], delay: delay_r[gi],
                            silence: sil_r[gi]};
    assign act[gi] = chan_sts[gi].active;
    dsa_chan u_chan (
      .clk(clk),
      .rst(rst),
      .sec_tick(sec_tick_r),
      .accept(btn_press[3]),
      .cfg(chan_cfg[gi]),
      .disp_value(disp_value),
      .sts(chan_sts[gi])
    );
  end

  // switch is sense xor active; annunciator steady when active, flashing in delay or silence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_sw <= 2'h0;
      annunciator <= 2'h0;
      act_q_r <= 2'h0;
    end else begin
      act_q_r <= act;
      for (int i = 0; i < 2; i++) begin
        alarm_sw[i] <= sense_r[i] ^ act[i];
        annunciator[i] <= act[i] || (blink_r && (chan_sts[i].delaying
                                                 || chan_sts[i].silent));
      end
    end
  end

  // alternation follows output activation only, never the delay
  assign sel_ok = (display_sel == 2'h0) || (display_sel == 2'h1 && act[0])
                  || (display_sel == 2'h2 && act[1]);
  assign pick_ch = (act == 2'h3) ? !last_ch_r : act[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_sel <= 2'h0;
      last_ch_r <= 1'b1;
    end else if (!alt_r || !sel_ok) begin
      display_sel <= 2'h0;
    end else if (sec_tick_r) begin
      if (display_sel != 2'h0) begin
        display_sel <= 2'h0;
      end else if (act != 2'h0) begin
        display_sel <= pick_ch ? 2'h2 : 2'h1;
        last_ch_r <= pick_ch;
      end
    end
  end

  // digit editor: most significant digit first, program steps on
  assign ed_start = wr_edit && hwdata[0];
  assign ed_commit = (ed_state_r == ED_DIGIT) && btn_press[2] && ed_digit_r == 3'h0;
  assign ed_ok = in_range(ed_val_r, lo_lim_r, hi_lim_r);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ed_state_r <= ED_IDLE;
      ed_tgt_r <= 1'b0;
      ed_digit_r <= 3'h0;
      ed_val_r <= 18'sh00000;
    end else if (ed_start) begin
      ed_state_r <= ED_DIGIT;
      ed_tgt_r <= hwdata[1];
      ed_digit_r <= DSA_EDIT_TOP_DIGIT;
      ed_val_r <= 18'(trip_r[hwdata[1]]);
    end else if (ed_state_r == ED_DIGIT) begin
      if (btn_press[2]) begin
        if (ed_digit_r == 3'h0) begin
          ed_state_r <= ED_IDLE;
        end else begin
          ed_digit_r <= ed_digit_r - 3'h1;
        end
      end else if (btn_press[0]) begin
        ed_val_r <= ed_val_r + digit_weight(ed_digit_r);
      end else if (btn_press[1]) begin
        ed_val_r <= ed_val_r - digit_weight(ed_digit_r);
      end
    end
  end

  // sticky events; a new event wins over a same-cycle clear
  assign irq_evt = {(ed_commit && !ed_ok) || (|(wr_trip & ~trip_ok)), act & ~act_q_r};
  assign irq_stat_nxt = (irq_stat_r & ~(wr_stat ? hwdata[2:0] : 3'h0)) | irq_evt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= wr_mask ? hwdata[2:0] : irq_mask_r;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_switch_sense: assert property (##1 alarm_sw[0] == ($past(sense_r[0]) ^ $past(act[0])))
    else $error("switch state disagrees with sense");
  a_alt_needs_act: assert property (display_sel == 2'h1 |-> $past(act[0]) && $past(alt_r))
    else $error("display alternates without active output");
  a_ann_steady: assert property (act[1] |=> annunciator[1])
    else $error("annunciator not steady while active");
  a_edit_reject: assert property (ed_commit && !ed_ok && !wr_trip[ed_tgt_r]
    |=> $stable(trip_r[ed_tgt_r]))
    else $error("out of range setpoint accepted");
  a_edit_step: assert property ((ed_state_r == ED_DIGIT) && !ed_start && btn_press[0]
    && !btn_press[2] |=> ed_val_r == $past(ed_val_r) + $past(digit_weight(ed_digit_r)))
    else $error("up button did not add digit weight");

  c_both_active: cover property (act == 2'h3);
  c_alt_shown: cover property (display_sel == 2'h2);

endmodule

// file: tb/dsa_panel.sv
`timescale 1ns/10ps
module dsa_panel (
  // clock
  input wire logic clk,
  // one-cycle press requests: up, down, prog, accept
  input wire logic [3:0] req,
  // button levels
  output logic [3:0] btn
);
  logic [1:0] hold_r;
  initial begin
    btn = 4'h0;
    hold_r = 2'h0;
  end
  // a press stands three cycles, then the button is let go
  always @(posedge clk) begin
    if (req != 4'h0) begin
      btn <= req;
      hold_r <= 2'h2;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end else begin
      btn <= 4'h0;
    end
  end
endmodule

// file: tb/dual_setpoint_alarm_logic_tb.sv
`timescale 1ns/10ps
module dual_setpoint_alarm_logic_tb;
  import dsa_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans, alarm_sw, annunciator, display_sel;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic signed [15:0] disp;
  logic [3:0] req, btn;
  int errors, tests_run, i;
  // rows: offset, write data, readback
  logic [7:0] ra [7] = '{8'h08, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h14, 8'h30};
  logic [31:0] rw [7] = '{32'h64, 32'h3000, 32'h32, 32'h5000A, 32'hFFF0000, 32'h0, 32'h5A};
  logic [31:0] re [7] = '{32'h64, 32'h64, 32'h32, 32'h5000A, 32'hE100000, 32'h0, 32'h0};

  dsa_top #(.HALF_SEC_CYC(8)) u_dsa_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .disp_value(disp),
    .btn_up(btn[0]), .btn_down(btn[1]), .btn_prog(btn[2]), .btn_accept(btn[3]),
    .alarm_sw(alarm_sw), .annunciator(annunciator), .display_sel(display_sel), .irq(irq));
  dsa_panel u_dsa_panel (.clk(clk), .req(req), .btn(btn));

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up;
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // hready is sampled at the edge; a stuck bus ends the run
  task hw_wait;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hw_wait();
    htrans <= 2'h0;
    hwdata <= d;
    hw_wait();
    rd = hrdata;
  endtask
  task wait_sw(input int b, input logic v);
    int n;
    for (n = 0; n < 80 && alarm_sw[b] !== v; n++) @(posedge clk);
    chk(alarm_sw[b], v);
    if (alarm_sw[b] !== v) wrap_up();
  endtask
  task press(input int n);
    req <= 4'h1 << n;
    @(posedge clk);
    req <= 4'h0;
    cyc(7);
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // register rows first, then alarm behaviour and the awkward cases
  initial begin
    rst = 1'b1;
    {hsel, htrans, haddr, hwrite, hwdata, req, errors, tests_run} = '0;
    hsize = 3'h2;
    disp = 16'sh004B;
    cyc(4);
    rst <= 1'b0;
    @(posedge clk);
    chk({alarm_sw, annunciator, display_sel, irq, hreadyout, hresp}, 32'h2);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h278DFF83);
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h22);
    for (i = 0; i < 7; i++) begin
      ahb(1'b1, ra[i], rw[i]);
      ahb(1'b0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h4);
    ahb(1'b1, 8'h20, 32'h4);
    ahb(1'b1, 8'h24, 32'h1);
    ahb(1'b1, 8'h00, 32'h153);
    cyc(4);
    chk(alarm_sw, 32'h2);
    disp <= 16'sh0064;
    wait_sw(0, 1'b1);
    chk(annunciator, 32'h1);
    @(posedge clk);
    chk(irq, 1'b1);
    for (i = 0; i < 40 && display_sel !== 2'h1; i++) @(posedge clk);
    chk(display_sel, 32'h1);
    if (display_sel !== 2'h1) wrap_up();
    disp <= 16'sh005F;
    cyc(4);
    chk(alarm_sw[0], 1'b1);
    disp <= 16'sh0059;
    wait_sw(0, 1'b0);
    cyc(2);
    chk(display_sel, 32'h0);
    ahb(1'b1, 8'h20, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    // low alarm on the second channel, closed when quiet
    disp <= 16'sh0028;
    wait_sw(1, 1'b0);
    disp <= 16'sh0036;
    cyc(4);
    chk(alarm_sw[1], 1'b0);
    disp <= 16'sh0038;
    wait_sw(1, 1'b1);
    ahb(1'b1, 8'h00, 32'h152);
    disp <= 16'sh0064;
    cyc(4);
    chk(alarm_sw[0], 1'b0);
    ahb(1'b1, 8'h14, 32'h2);
    ahb(1'b1, 8'h00, 32'h153);
    cyc(4);
    // lamp must light at some point while the delay runs
    for (i = 0; i < 10 && annunciator[0] !== 1'b1; i++) @(posedge clk);
    chk(annunciator[0], 1'b1);
    chk(alarm_sw[0], 1'b0);
    ahb(1'b0, 8'h1C, 32'h0);
    chk(rd[1], 1'b1);
    chk(display_sel, 32'h0);
    // a short break must restart the whole delay
    disp <= 16'sh004B;
    cyc(2);
    disp <= 16'sh0064;
    cyc(12);
    chk(alarm_sw[0], 1'b0);
    wait_sw(0, 1'b1);
    ahb(1'b1, 8'h18, 32'h3);
    press(3);
    chk(alarm_sw[0], 1'b0);
    ahb(1'b0, 8'h1C, 32'h0);
    chk(rd[0], 1'b1);
    // silenced lamp flashes, so it must go dark within a blink period
    for (i = 0; i < 20 && annunciator[0] !== 1'b0; i++) @(posedge clk);
    chk(annunciator[0], 1'b0);
    wait_sw(0, 1'b1);
    // edit: thousands digit up twice, down once, then commit
    ahb(1'b1, 8'h28, 32'h1);
    press(2);
    press(0);
    press(0);
    press(1);
    repeat (4) press(2);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h44C);
    // edit second setpoint past the upper limit: commit is refused
    ahb(1'b1, 8'h28, 32'h3);
    press(0);
    press(0);
    repeat (5) press(2);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h32);
    ahb(1'b0, 8'h20, 32'h0);
    chk(rd[2], 1'b1);
    // reset in mid run brings back the quiet state and cleared setpoints
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    chk({alarm_sw, annunciator, display_sel, irq, hreadyout, hresp}, 32'h2);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
